// [hdl/bws_pkg.sv]
// Package for the board watchdog and reset supervisor.
// Assumes a single 250 MHz clock domain.
package bws_pkg;

    // Clock rate and derived second tick
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned TICK_CYCLES     = CLK_HZ;
    localparam int unsigned TICK_W          = 28;

    // Watchdog periods in seconds
    localparam logic [7:0]  WDT_SEC_2       = 8'h02;
    localparam logic [7:0]  WDT_SEC_10      = 8'h0a;
    localparam logic [7:0]  WDT_SEC_50      = 8'h32;
    localparam logic [7:0]  WDT_SEC_255     = 8'hff;

    // Handle override time in seconds
    localparam logic [7:0]  OVR_SEC         = 8'h04;

    // Blink half period in ticks of the second counter fraction
    localparam int unsigned BLINK_BIT       = 26;

    // Register offsets
    localparam logic [3:0]  ADR_WDT_CTRL    = 4'h0;
    localparam logic [3:0]  ADR_WDT_TRIG    = 4'h1;
    localparam logic [3:0]  ADR_CONFIG      = 4'h2;
    localparam logic [3:0]  ADR_STATUS      = 4'h3;
    localparam logic [3:0]  ADR_IRQ_STAT    = 4'h4;
    localparam logic [3:0]  ADR_IRQ_CLR     = 4'h5;
    localparam logic [3:0]  ADR_IRQ_EN      = 4'h6;

    // Field positions
    localparam int unsigned CFG_RST_DIS     = 0;
    localparam int unsigned CFG_PWRBTN_DIS  = 1;
    localparam int unsigned EV_WDT_EXP      = 0;
    localparam int unsigned EV_OVERRIDE     = 1;
    localparam int unsigned EV_PWRBTN       = 2;
    localparam int unsigned EV_MANRST       = 3;
    localparam int unsigned EV_W            = 4;

    // Reset values
    localparam logic [1:0]  WDT_SEL_RST     = 2'h0;
    localparam logic [1:0]  CFG_RST         = 2'h0;
    localparam logic [3:0]  EV_RST          = 4'h0;
    localparam logic [7:0]  RST_PULSE_CYC   = 8'h10;

    typedef enum logic [1:0]
    {
        BWS_SEL_2   = 2'b00,
        BWS_SEL_10  = 2'b01,
        BWS_SEL_50  = 2'b10,
        BWS_SEL_255 = 2'b11
    } bws_sel_t;

    typedef enum logic [1:0]
    {
        BWS_PWR_BOOT = 2'b00,
        BWS_PWR_S0   = 2'b01,
        BWS_PWR_S5   = 2'b10,
        BWS_PWR_OPEN = 2'b11
    } bws_pwr_t;

    typedef struct packed
    {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bws_req_t;

    typedef struct packed
    {
        logic green;
        logic yellow;
        logic red;
    } bws_led_t;

    function automatic logic [7:0] bws_period(input logic [1:0] sel);
        logic [7:0] p;
        p = WDT_SEC_2;
        unique case (sel)
            BWS_SEL_2:   p = WDT_SEC_2;
            BWS_SEL_10:  p = WDT_SEC_10;
            BWS_SEL_50:  p = WDT_SEC_50;
            BWS_SEL_255: p = WDT_SEC_255;
        endcase
        return p;
    endfunction

endpackage

// [hdl/bws_sync.sv]
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/10ps
module bws_sync #(
    parameter int unsigned W     = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta_r <= INIT;
            q      <= INIT;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// [hdl/bws_top.sv]
// Board watchdog, handle power-button logic, reset and healthy indicator.
// Assumes rst_n is the board system reset; pins are asynchronous.
// Overview of operation
// - Watchdog period is chosen from 2, 10, 50 or 255 seconds.
// - After system reset the watchdog is passive and never expires.
// - First trigger request after reset makes the watchdog active.
// - Active and trigger gap longer than period: expire, force full board reset.
// - Active state holds until next system reset; no write clears it.
// - Period selection writable any time, new period takes effect.
// - Handle open for 4 seconds raises override, board goes to S5.
// - In S5 after override, unlock then lock returns board to S0.
// - Handle open during power up sends board to S5.
// - Handle push button gives one power-button pulse.
// - Backplane reset input low resets board like the front switch.
// - Config bits disable manual reset switch and handle power button.
// - Healthy green only when all rails good and board reset released.
// - Healthy indicator blinks yellow while the handle is open.
`timescale 1ns/10ps
module bws_top
#(
    // One second in mclk cycles; a bench may shorten it
    parameter int unsigned TICK_CYCLES = bws_pkg::TICK_CYCLES
)
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        reset_switch_n,
    input  wire logic        backplane_reset_in_n,
    input  wire logic        handle_open,
    input  wire logic        handle_button_n,
    input  wire logic        rails_good,
    output logic             board_reset_n,
    output logic             power_button_pulse,
    output logic             power_override,
    output logic             soft_off,
    output bws_pkg::bws_led_t healthy_indicator,
    output logic             irq
);
    bws_pkg::bws_req_t req;
    logic [4:0]  pins_s;
    logic        rst_sw_n_s;
    logic        bp_rst_n_s;
    logic        handle_s;
    logic        button_n_s;
    logic        rails_s;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Idle levels: switches released, handle closed, rails good
    bws_sync #(.W(5), .INIT(5'h1b)) u_sync
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({reset_switch_n, backplane_reset_in_n, handle_open, handle_button_n,
                 rails_good}),
        .q     (pins_s)
    );
    assign {rst_sw_n_s, bp_rst_n_s, handle_s, button_n_s, rails_s} = pins_s;

    // Pin samples are stale for two edges after reset
    logic [1:0] pins_ok_r;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pins_ok_r <= 2'b00;
        else
            pins_ok_r <= {pins_ok_r[0], 1'b1};
    end

    // Second tick shared by watchdog, override timer and blink
    logic [bws_pkg::TICK_W-1:0] tick_cnt_r;
    logic                       tick;
    assign tick = (tick_cnt_r == bws_pkg::TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge mclk)
    begin
        if (!rst_n || tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 1'b1;
    end

    // Registers
    logic [1:0]             wdt_sel_r;
    logic [1:0]             cfg_r;
    logic [bws_pkg::EV_W-1:0] ev_stat_r;
    logic [bws_pkg::EV_W-1:0] ev_en_r;
    logic [bws_pkg::EV_W-1:0] ev_set;
    logic                   wr_sel;
    logic                   wr_trig;
    logic                   wr_clr;

    assign wr_sel  = req.wr && (req.addr == bws_pkg::ADR_WDT_CTRL);
    assign wr_trig = req.wr && (req.addr == bws_pkg::ADR_WDT_TRIG);
    assign wr_clr  = req.wr && (req.addr == bws_pkg::ADR_IRQ_CLR);

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            wdt_sel_r <= bws_pkg::WDT_SEL_RST;
        else if (wr_sel)
            wdt_sel_r <= req.wdata[1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cfg_r <= bws_pkg::CFG_RST;
        else if (req.wr && req.addr == bws_pkg::ADR_CONFIG)
            cfg_r <= req.wdata[1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ev_en_r <= bws_pkg::EV_RST;
        else if (req.wr && req.addr == bws_pkg::ADR_IRQ_EN)
            ev_en_r <= req.wdata[bws_pkg::EV_W-1:0];
    end

    // Set wins over clear
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ev_stat_r <= bws_pkg::EV_RST;
        else
            ev_stat_r <= (ev_stat_r & ~(wr_clr ? req.wdata[bws_pkg::EV_W-1:0]
                                               : {bws_pkg::EV_W{1'b0}})) | ev_set;
    end

    assign irq = |(ev_stat_r & ev_en_r);

    // Watchdog
    logic       wdt_active_r;
    logic [8:0] wdt_sec_r;
    logic       wdt_expire;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            wdt_active_r <= 1'b0;
        else if (wr_trig)
            wdt_active_r <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n || wr_trig || wr_sel)
            wdt_sec_r <= '0;
        else if (tick && wdt_active_r && !wdt_expire)
            wdt_sec_r <= wdt_sec_r + 1'b1;
    end

    // Strictly past the period, so the free tick phase never shortens it
    assign wdt_expire = wdt_active_r &&
                        (wdt_sec_r > {1'b0, bws_pkg::bws_period(wdt_sel_r)});

    // Board reset: watchdog, switch or backplane, stretched
    logic       man_rst;
    logic       rst_req;
    logic [7:0] rst_cnt_r;

    assign man_rst = (!rst_sw_n_s && !cfg_r[bws_pkg::CFG_RST_DIS]) || !bp_rst_n_s;
    assign rst_req = man_rst || wdt_expire;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rst_cnt_r <= bws_pkg::RST_PULSE_CYC;
        else if (rst_req)
            rst_cnt_r <= bws_pkg::RST_PULSE_CYC;
        else if (rst_cnt_r != 8'h00)
            rst_cnt_r <= rst_cnt_r - 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            board_reset_n <= 1'b0;
        else
            board_reset_n <= (rst_cnt_r == 8'h00) && !rst_req;
    end

    // Handle power-state machine
    bws_pkg::bws_pwr_t pwr_r;
    bws_pkg::bws_pwr_t pwr_nxt;
    logic [7:0]        ovr_sec_r;
    logic              handle_d_r;
    logic              button_d_r;
    logic              pb_en;
    logic              ovr_hit;

    assign pb_en   = !cfg_r[bws_pkg::CFG_PWRBTN_DIS];
    // Full override time must pass whatever the tick phase
    assign ovr_hit = handle_s && (ovr_sec_r > bws_pkg::OVR_SEC);

    always_ff @(posedge mclk)
    begin
        if (!rst_n || !handle_s)
            ovr_sec_r <= '0;
        else if (tick && !ovr_hit)
            ovr_sec_r <= ovr_sec_r + 1'b1;
    end

    always_comb
    begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            bws_pkg::BWS_PWR_BOOT:
                if (pins_ok_r[1])
                    pwr_nxt = handle_s ? bws_pkg::BWS_PWR_S5 : bws_pkg::BWS_PWR_S0;
            bws_pkg::BWS_PWR_S0:
                if (ovr_hit && pb_en)
                    pwr_nxt = bws_pkg::BWS_PWR_S5;
            bws_pkg::BWS_PWR_S5:
                if (handle_s && !handle_d_r && pb_en)
                    pwr_nxt = bws_pkg::BWS_PWR_OPEN;
            bws_pkg::BWS_PWR_OPEN:
                if (!handle_s)
                    pwr_nxt = bws_pkg::BWS_PWR_S0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pwr_r      <= bws_pkg::BWS_PWR_BOOT;
            handle_d_r <= 1'b0;
            button_d_r <= 1'b1;
        end
        else
        begin
            pwr_r      <= pwr_nxt;
            handle_d_r <= handle_s;
            button_d_r <= button_n_s;
        end
    end

    logic pb_edge;
    assign pb_edge = !button_n_s && button_d_r && pb_en;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            power_button_pulse <= 1'b0;
            power_override     <= 1'b0;
            soft_off           <= 1'b0;
        end
        else
        begin
            power_button_pulse <= pb_edge;
            power_override     <= ovr_hit && pb_en && (pwr_r == bws_pkg::BWS_PWR_S0);
            soft_off           <= (pwr_nxt == bws_pkg::BWS_PWR_S5) ||
                                  (pwr_nxt == bws_pkg::BWS_PWR_OPEN);
        end
    end

    assign ev_set = {man_rst, pb_edge,
                     ovr_hit && pb_en && (pwr_r == bws_pkg::BWS_PWR_S0),
                     wdt_expire};

    // Yellow blink toggles once a second
    logic blink_r;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            blink_r <= 1'b0;
        else if (tick)
            blink_r <= !blink_r;
    end

    // Healthy indicator
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            healthy_indicator <= '0;
        else if (handle_s)
            healthy_indicator <= '{green: 1'b0, red: 1'b0,
                                   yellow: blink_r};
        else
            healthy_indicator <= '{green: rails_s && board_reset_n &&
                                          (pwr_r == bws_pkg::BWS_PWR_S0),
                                   red: !rails_s, yellow: 1'b0};
    end

    // Read port
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !req.rd)
            reg_rdata <= '0;
        else
        begin
            unique case (req.addr)
                bws_pkg::ADR_WDT_CTRL: reg_rdata <= {30'h0, wdt_sel_r};
                bws_pkg::ADR_CONFIG:   reg_rdata <= {30'h0, cfg_r};
                bws_pkg::ADR_STATUS:   reg_rdata <= {24'h0, wdt_sec_r[3:0], pwr_r,
                                                     handle_s, wdt_active_r};
                bws_pkg::ADR_IRQ_STAT: reg_rdata <= {28'h0, ev_stat_r};
                bws_pkg::ADR_IRQ_EN:   reg_rdata <= {28'h0, ev_en_r};
                default:               reg_rdata <= '0;
            endcase
        end
    end
endmodule

// [dv/bws_top_properties.sv]
// Port-level assertions for the board supervisor.
// Assumes one mclk domain with synchronous active-low rst_n.
`timescale 1ns/10ps
module bws_top_properties
(
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic [3:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              backplane_reset_in_n,
    input wire logic              handle_button_n,
    input wire logic              board_reset_n,
    input wire logic              power_button_pulse,
    input wire bws_pkg::bws_led_t healthy_indicator
);
    logic       armed_r;
    logic [1:0] sel_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Shadow of trigger and period writes
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            armed_r <= 1'b0;
            sel_r   <= bws_pkg::WDT_SEL_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == bws_pkg::ADR_WDT_TRIG)
            begin
                armed_r <= 1'b1;
            end
            if (reg_addr == bws_pkg::ADR_WDT_CTRL)
            begin
                sel_r <= reg_wdata[1:0];
            end
        end
    end

    property p_rst_rel;
        $rose(rst_n) |-> !board_reset_n && !healthy_indicator.green;
    endproperty
    a_rst_rel: assert property (p_rst_rel) else $error("outputs not quiet at release");

    property p_rd_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

    property p_sel;
        reg_rd && reg_addr == bws_pkg::ADR_WDT_CTRL |=> reg_rdata[1:0] == sel_r;
    endproperty
    a_sel: assert property (p_sel) else $error("period field readback wrong");

    property p_active;
        reg_rd && reg_addr == bws_pkg::ADR_STATUS && armed_r |=> reg_rdata[0];
    endproperty
    a_active: assert property (p_active) else $error("watchdog not active after trigger");

    property p_bp;
        !backplane_reset_in_n [*3] |-> ##[0:6] !board_reset_n;
    endproperty
    a_bp: assert property (p_bp) else $error("backplane reset not passed on");

    property p_stretch;
        $fell(board_reset_n) |=> !board_reset_n [*8];
    endproperty
    a_stretch: assert property (p_stretch) else $error("board reset too short");

    property p_pulse_one;
        power_button_pulse |=> !power_button_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("button pulse longer than one cycle");

    property p_pulse_cause;
        power_button_pulse |-> !$past(handle_button_n, 2) || !$past(handle_button_n, 3)
            || !$past(handle_button_n, 4) || !$past(handle_button_n, 5);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without button");

    property p_green;
        $rose(healthy_indicator.green) |-> board_reset_n;
    endproperty
    a_green: assert property (p_green) else $error("green while board in reset");

    c_pulse: cover property (power_button_pulse);
    c_reset: cover property ($fell(board_reset_n));
    c_armed: cover property (reg_rd && armed_r);
endmodule

bind bws_top bws_top_properties u_props (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .backplane_reset_in_n, .handle_button_n, .board_reset_n,
    .power_button_pulse, .healthy_indicator);

// [dv/bws_board_model.sv]
// Board-side model: reset switch, backplane reset, handle and rails.
// Assumes the bench sets the wanted pin levels on want.
`timescale 1ns/10ps
module bws_board_model
(
    input  wire logic       mclk,
    input  wire logic [4:0] want,
    output logic            reset_switch_n,
    output logic            backplane_reset_in_n,
    output logic            handle_open,
    output logic            handle_button_n,
    output logic            rails_good
);
    initial
    begin
        {rails_good, handle_button_n, handle_open, backplane_reset_in_n, reset_switch_n} = want;
    end

    // Pins move just after the edge, like a slow mechanical source
    always @(posedge mclk)
    begin
        {rails_good, handle_button_n, handle_open, backplane_reset_in_n, reset_switch_n} <= want;
    end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the board supervisor.
// Runs with a shortened second of T mclk cycles; long periods are not run out.
`timescale 1ns/10ps
module testbench;
    localparam logic [4:0] IDLE = 5'h1b;
    localparam int         T    = 100; // Shortened second
    logic              mclk;
    logic              rst_n;
    logic [3:0]        reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [31:0]       reg_rdata;
    logic [4:0]        want;
    logic              sw_n, bp_n, hopen, btn_n, rails;
    logic              board_reset_n, pulse, soft_off, irq, ovr_o;
    bws_pkg::bws_led_t led;
    int                mismatches, checks, pulses, n0, cyc, ylw;
    logic [31:0]       seed;
    logic [1:0]        sel;

    bws_board_model u_board (.mclk, .want, .reset_switch_n(sw_n), .backplane_reset_in_n(bp_n),
        .handle_open(hopen), .handle_button_n(btn_n), .rails_good(rails));
    bws_top #(.TICK_CYCLES(T)) DUT (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reset_switch_n(sw_n), .backplane_reset_in_n(bp_n), .handle_open(hopen),
        .handle_button_n(btn_n), .rails_good(rails), .board_reset_n,
        .power_button_pulse(pulse), .power_override(ovr_o), .soft_off,
        .healthy_indicator(led), .irq);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] stat(input logic act, input logic [1:0] pwr);
        return {28'h0, pwr, 1'b0, act};
    endfunction

    task automatic tally_and_finish();
        if (mismatches == 0 && checks > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata & m, e);
    endtask

    task automatic pins(input logic [4:0] p, input int hold);
        @(posedge mclk);
        want <= p;
        repeat (hold) @(posedge mclk);
        #1;
    endtask

    task automatic wait_rst(input logic lvl);
        for (int n = 0; n < 60 && board_reset_n !== lvl; n++)
        begin
            @(posedge mclk);
            #1;
        end
        check(board_reset_n, lvl);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        if (pulse === 1'b1)
        begin
            pulses <= pulses + 1;
        end
    end

    initial
    begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    initial
    begin
        {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {mismatches, checks, pulses} = '0;
        want = IDLE | 5'h04;
        seed = 32'h37;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (30) @(posedge mclk);
        #1;
        check(soft_off, 1'b1);
        rd(bws_pkg::ADR_STATUS, 32'h8, 32'h8);
        // Second reset, handle closed this time
        pins(IDLE, 0);
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        wait_rst(1'b1);
        repeat (4) @(posedge mclk);
        #1;
        check(led.green, 1'b1);
        rd(bws_pkg::ADR_STATUS, 32'hf, stat(1'b0, 2'h1));
        for (int i = 0; i < 6; i++)
        begin
            sel = (i < 4) ? i[1:0] : rnd() & 32'h3;
            wr(bws_pkg::ADR_WDT_CTRL, {30'h0, sel});
            rd(bws_pkg::ADR_WDT_CTRL, 32'h3, {30'h0, sel});
            if (i == 4)
            begin
                wr(bws_pkg::ADR_WDT_TRIG, rnd());
                rd(bws_pkg::ADR_STATUS, 32'h1, 32'h1);
            end
        end
        // Longest period keeps the armed watchdog quiet until its own test
        wr(bws_pkg::ADR_WDT_CTRL, {30'h0, bws_pkg::BWS_SEL_255});
        rd(bws_pkg::ADR_STATUS, 32'h1, 32'h1);
        wr(bws_pkg::ADR_IRQ_EN, 32'hf);
        n0 = pulses;
        pins(IDLE & 5'h17, 8);
        pins(IDLE, 8);
        check(pulses - n0, 1);
        check(irq, 1'b1);
        rd(bws_pkg::ADR_IRQ_STAT, 32'hf, 32'h4);
        wr(bws_pkg::ADR_IRQ_CLR, 32'hf);
        check(irq, 1'b0);
        wr(bws_pkg::ADR_CONFIG, 32'h3);
        pins(IDLE & 5'h17, 8);
        pins(IDLE & 5'h1e, 20);
        check(pulses - n0, 1);
        check(board_reset_n, 1'b1);
        pins(IDLE, 2);
        wr(bws_pkg::ADR_IRQ_EN, 32'h0);
        pins(IDLE & 5'h1d, 1);
        wait_rst(1'b0);
        pins(IDLE, 1);
        wait_rst(1'b1);
        check(irq, 1'b0);
        rd(bws_pkg::ADR_IRQ_STAT, 32'hf, 32'h8);
        wr(bws_pkg::ADR_CONFIG, 32'h0);
        pins(IDLE & 5'h1e, 1);
        wait_rst(1'b0);
        pins(IDLE, 1);
        wait_rst(1'b1);
        rd(4'hf, 32'hffffffff, 32'h0);
        // Handle held open until the override, blinking meanwhile
        ylw = 0;
        pins(IDLE | 5'h04, 0);
        for (cyc = 0; cyc < 6 * T && soft_off !== 1'b1; cyc++)
        begin
            @(posedge mclk);
            #1;
            ylw += led.yellow;
        end
        check(ovr_o, 1'b1);
        check(cyc >= bws_pkg::OVR_SEC * T, 1'b1);
        check(cyc <= (bws_pkg::OVR_SEC + 1) * T + 4, 1'b1);
        check(ylw > 0 && ylw < cyc, 1'b1);
        check(led.green, 1'b0);
        pins(IDLE, 8);
        check(soft_off, 1'b1);
        pins(IDLE | 5'h04, 8);
        check(soft_off, 1'b1);
        pins(IDLE, 8);
        check(soft_off, 1'b0);
        rd(bws_pkg::ADR_STATUS, 32'hc, 32'h4);
        // Short period while active; triggers inside it keep the board up
        wr(bws_pkg::ADR_WDT_CTRL, {30'h0, bws_pkg::BWS_SEL_2});
        for (int i = 0; i < 4; i++)
        begin
            repeat (3 * T / 2) @(posedge mclk);
            wr(bws_pkg::ADR_WDT_TRIG, rnd());
        end
        check(board_reset_n, 1'b1);
        for (cyc = 0; cyc < 4 * T && board_reset_n !== 1'b0; cyc++)
        begin
            @(posedge mclk);
            #1;
        end
        check(cyc > bws_pkg::WDT_SEC_2 * T, 1'b1);
        check(cyc <= (bws_pkg::WDT_SEC_2 + 1) * T + 2, 1'b1);
        repeat (50) @(posedge mclk);
        #1;
        check(board_reset_n, 1'b0);
        // System reset brings a passive watchdog back
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        wait_rst(1'b1);
        repeat (4 * T) @(posedge mclk);
        #1;
        check(board_reset_n, 1'b1);
        rd(bws_pkg::ADR_STATUS, 32'h1, 32'h0);
        tally_and_finish();
    end
endmodule
